// [design/cpt_map.svh]
// register map, field positions and codes of the compact timer
// assumes: included by bare name from the package and the top module
`ifndef CPT_MAP_SVH
`define CPT_MAP_SVH

// byte offsets on the register bus, one aligned word each
`define CPT_OFF_ONOFF   8'h00
`define CPT_OFF_CTRL    8'h04
`define CPT_OFF_CNT_LO  8'h08
`define CPT_OFF_CNT_HI  8'h0C
`define CPT_OFF_CMPA_LO 8'h10
`define CPT_OFF_CMPA_HI 8'h14
`define CPT_OFF_CMPP    8'h18
`define CPT_OFF_STATUS  8'h1C

// field positions inside timer_control_one
`define CPT_BIT_SEL     0
`define CPT_BIT_SWAP    1
`define CPT_BIT_INV     2
`define CPT_BIT_INIT    3
`define CPT_ACT_LO      4
`define CPT_ACT_HI      5
`define CPT_MODE_LO     6
`define CPT_MODE_HI     7

// field positions inside the on/off and status words
`define CPT_BIT_ON      0
`define CPT_BIT_FLAG_A  0
`define CPT_BIT_FLAG_P  1

// reset values and pin-action codes
`define CPT_RST_BYTE    8'h00
`define CPT_RST_WORD    16'h0000
`define CPT_ACT_NONE    2'h0
`define CPT_ACT_LOW     2'h1
`define CPT_ACT_HIGH    2'h2
`define CPT_ACT_TOGGLE  2'h3

// response codes of the bus
`define CPT_RESP_OKAY   2'h0
`define CPT_RESP_SLVERR 2'h2

`endif

// [design/cpt_pkg.sv]
// types of the compact timer: operating modes and the state record
// assumes: cpt_map.svh sits in the include path
package cpt_pkg;
	`include "cpt_map.svh"

	// operating mode codes as held in the mode field
	typedef enum logic [1:0] {
		CPT_MODE_CMP  = 2'h0,
		CPT_MODE_UNDF = 2'h1,
		CPT_MODE_PWM  = 2'h2,
		CPT_MODE_TC   = 2'h3
	} cpt_mode_e;

	// whole state of the top module in one record
	typedef struct packed {
		logic        on;
		logic [7:0]  ctl;
		logic [15:0] cnt;
		logic [15:0] cmpa;
		logic [7:0]  cmpp;
		logic        flag_a;
		logic        flag_p;
		logic        pin;
		logic        out;
		logic        oe;
		logic        tick_d;
		logic        aw_got;
		logic [7:0]  awaddr;
		logic        w_got;
		logic [7:0]  wdata;
		logic        wstrb0;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} cpt_state_s;
endpackage

// [design/cpt_sync.sv]
// two-stage synchroniser for a level arriving from outside the clock
// assumes: aclk is the only clock; reset is synchronous, active low
`timescale 1ns/1ps
module cpt_sync (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// level in and synchronised level out
	input  wire logic d,
	output logic      q
);
	// both stages of the synchroniser in one record
	typedef struct packed {
		logic stage1;
		logic stage2;
	} cpt_sync_s;

	cpt_sync_s s_r;
	cpt_sync_s s_nxt;

	// the first stage feeds only the second one, so no logic sees metastability
	always_comb begin
		s_nxt = s_r;
		s_nxt.stage1 = d;
		s_nxt.stage2 = s_r.stage1;
	end

	// stage register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.stage2;
endmodule

// [design/cpt_top.sv]
// compact 16-bit timer with two comparators, behind an AXI4-Lite slave
// assumes: count_clk_in is the selected count clock, asynchronous to aclk
//
// Summary of operation
// - counter readable as two read-only bytes, low and high, zero at reset
// - comparator A value in two writable bytes, both reset to zero
// - comparator P byte compared only with counter bits 15 to 8
// - P match period is 256 times value; zero gives 65536 clocks
// - clear-source low: P match clears counter; zero P clears on overflow
// - mode 00 compare output, 11 timer/counter, 10 PWM
// - compare mode, clear-source low: both match flags set on their matches
// - clear-source high: A match clears counter; only A flag is set
// - clear-source high, A value zero: overflow at FFFF without A flag
// - compare mode: while on, pin changes only on an A match, never on P
// - A match drives pin low, high or toggles; zero action no change
// - counter-on rising loads pin with the initial level bit
// - timer/counter mode counts and flags like compare, pin not driven
// - PWM ignores clear-source; swap bit picks period and duty comparator
// - swap zero: period is P value times 256 (65536 at zero), duty A
// - duty at or above period gives 100 percent duty
// - swap one: period is A value, duty is P value times 256
// - PWM mode sets A flag on A match and P flag on P match
// - PWM: initial bit sets active level, action enables, invert flips
// - counting and matching continue while action forces a fixed level
// - action decode: compare none/low/high/toggle; PWM inactive/active/wave
// - initial bit: compare start level; PWM active level, zero active low
`timescale 1ns/1ps
`include "cpt_map.svh"
module cpt_top
	import cpt_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// count clock from the clock selection
	input  wire logic              count_clk_in,
	// timer output pin
	output logic                   timer_out,
	output logic                   timer_out_oe,
	// write address channel
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	// write data channel
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	// write response channel
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// read address channel
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	// read data channel
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready
);
	// ************************************************************
	// parameter check
	// ************************************************************
	if (ADDR_W < 8) begin : g_bad_addr
		$error("cpt_top: ADDR_W must be at least 8");
	end

	// ************************************************************
	// declarations
	// ************************************************************
	cpt_state_s s_r;
	cpt_state_s s_nxt;
	logic       cnt_clk_s;
	logic       tick;
	logic       run;
	cpt_mode_e  mode;
	logic [15:0] cnt_inc;
	logic       hit_a;
	logic       hit_p;
	logic       clr;
	logic       set_a;
	logic       set_p;
	logic [16:0] duty;
	logic       wave_lvl;
	logic [1:0] act;
	logic       init_lvl;

	// true when the low address byte names a register of this block
	function automatic logic in_map(input logic [7:0] a);
		case (a)
			`CPT_OFF_ONOFF, `CPT_OFF_CTRL, `CPT_OFF_CNT_LO,
			`CPT_OFF_CNT_HI, `CPT_OFF_CMPA_LO, `CPT_OFF_CMPA_HI,
			`CPT_OFF_CMPP, `CPT_OFF_STATUS: in_map = 1'b1;
			default: in_map = 1'b0;
		endcase
	endfunction

	// word seen by a read of one register
	function automatic logic [31:0] rd_word(input cpt_state_s s,
		input logic [7:0] a);
		logic [7:0] b;
		b = `CPT_RST_BYTE;
		case (a)
			`CPT_OFF_ONOFF:   b = {7'h00, s.on};
			`CPT_OFF_CTRL:    b = s.ctl;
			`CPT_OFF_CNT_LO:  b = s.cnt[7:0];
			`CPT_OFF_CNT_HI:  b = s.cnt[15:8];
			`CPT_OFF_CMPA_LO: b = s.cmpa[7:0];
			`CPT_OFF_CMPA_HI: b = s.cmpa[15:8];
			`CPT_OFF_CMPP:    b = s.cmpp;
			`CPT_OFF_STATUS:  b = {6'h00, s.flag_p, s.flag_a};
			default:          b = `CPT_RST_BYTE;
		endcase
		rd_word = {24'h000000, b};
	endfunction

	// ************************************************************
	// count clock crossing
	// ************************************************************
	cpt_sync i_cpt_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (count_clk_in),
		.q       (cnt_clk_s)
	);

	// ************************************************************
	// next-state logic
	// ************************************************************
	always_comb begin
		s_nxt = s_r;
		mode = cpt_mode_e'(s_r.ctl[`CPT_MODE_HI:`CPT_MODE_LO]);
		act = s_r.ctl[`CPT_ACT_HI:`CPT_ACT_LO];
		init_lvl = s_r.ctl[`CPT_BIT_INIT];
		// a count happens on the rising edge of the synchronised clock
		tick = cnt_clk_s & ~s_r.tick_d;
		s_nxt.tick_d = cnt_clk_s;
		run = s_r.on & tick;
		cnt_inc = s_r.cnt + 16'h0001;
		// P compares the high byte only; zero matches at the wrap
		hit_p = (cnt_inc[7:0] == 8'h00) &&
			(cnt_inc[15:8] == s_r.cmpp);
		hit_a = (cnt_inc == s_r.cmpa);

		// clearing source and flag sources per mode
		if (mode == CPT_MODE_PWM) begin
			clr = s_r.ctl[`CPT_BIT_SWAP] ? hit_a : hit_p;
			set_a = hit_a;
			set_p = hit_p;
		end else if (s_r.ctl[`CPT_BIT_SEL]) begin
			// an all-zero A value just lets the counter wrap
			clr = hit_a && (s_r.cmpa != `CPT_RST_WORD);
			set_a = clr;
			set_p = 1'b0;
		end else begin
			clr = hit_p;
			set_a = hit_a;
			set_p = hit_p;
		end

		// counter steps and match-clears only on a count clock while on
		if (run) begin
			s_nxt.cnt = clr ? `CPT_RST_WORD : cnt_inc;
		end

		// compare mode pin acts only on an A match
		if (run && set_a && mode == CPT_MODE_CMP) begin
			case (act)
				`CPT_ACT_LOW:    s_nxt.pin = 1'b0;
				`CPT_ACT_HIGH:   s_nxt.pin = 1'b1;
				`CPT_ACT_TOGGLE: s_nxt.pin = ~s_r.pin;
				default:         s_nxt.pin = s_r.pin;
			endcase
		end

		// ---- write address and data, taken in either order ----
		if (awvalid && s_r.awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = awaddr[7:0];
		end
		if (wvalid && s_r.wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = wdata[7:0];
			s_nxt.wstrb0 = wstrb[0];
		end
		if (s_r.bvalid && bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_nxt.aw_got && s_nxt.w_got && !s_r.bvalid) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = in_map(s_nxt.awaddr) ? `CPT_RESP_OKAY :
				`CPT_RESP_SLVERR;
			if (s_nxt.wstrb0) begin
				case (s_nxt.awaddr)
					`CPT_OFF_ONOFF: begin
						s_nxt.on = s_nxt.wdata[`CPT_BIT_ON];
						// switching on restarts count and pin
						if (s_nxt.wdata[`CPT_BIT_ON] && !s_r.on) begin
							s_nxt.cnt = `CPT_RST_WORD;
							s_nxt.pin = init_lvl;
						end
					end
					`CPT_OFF_CTRL:    s_nxt.ctl = s_nxt.wdata;
					`CPT_OFF_CMPA_LO: s_nxt.cmpa[7:0] = s_nxt.wdata;
					`CPT_OFF_CMPA_HI: s_nxt.cmpa[15:8] = s_nxt.wdata;
					`CPT_OFF_CMPP:    s_nxt.cmpp = s_nxt.wdata;
					`CPT_OFF_STATUS: begin
						// write one to clear
						if (s_nxt.wdata[`CPT_BIT_FLAG_A]) begin
							s_nxt.flag_a = 1'b0;
						end
						if (s_nxt.wdata[`CPT_BIT_FLAG_P]) begin
							s_nxt.flag_p = 1'b0;
						end
					end
					default: s_nxt.on = s_r.on;
				endcase
			end
		end

		// flag set after the clear, so a same-cycle event is kept
		if (run && set_a) begin
			s_nxt.flag_a = 1'b1;
		end
		if (run && set_p) begin
			s_nxt.flag_p = 1'b1;
		end

		// ---- read channel ----
		if (s_r.rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = rd_word(s_r, araddr[7:0]);
			s_nxt.rresp = in_map(araddr[7:0]) ? `CPT_RESP_OKAY :
				`CPT_RESP_SLVERR;
		end
		s_nxt.awready = ~s_nxt.aw_got & ~s_nxt.bvalid;
		s_nxt.wready = ~s_nxt.w_got & ~s_nxt.bvalid;
		s_nxt.arready = ~s_nxt.rvalid;

		// ---- PWM waveform from the current count ----
		if (s_r.ctl[`CPT_BIT_SWAP]) begin
			duty = (s_r.cmpp == 8'h00) ? 17'h10000 :
				{1'b0, s_r.cmpp, 8'h00};
		end else begin
			duty = {1'b0, s_r.cmpa};
		end
		// duty at or beyond the period never ends the active phase
		case (act)
			`CPT_ACT_LOW:  wave_lvl = init_lvl;
			`CPT_ACT_HIGH: wave_lvl = ({1'b0, s_r.cnt} < duty) ?
				init_lvl : ~init_lvl;
			default:       wave_lvl = ~init_lvl;
		endcase

		// pin drive; timer/counter mode leaves the pin free
		case (mode)
			CPT_MODE_CMP: begin
				s_nxt.out = s_nxt.pin ^ s_r.ctl[`CPT_BIT_INV];
				s_nxt.oe = 1'b1;
			end
			CPT_MODE_PWM: begin
				s_nxt.out = wave_lvl ^ s_r.ctl[`CPT_BIT_INV];
				s_nxt.oe = 1'b1;
			end
			default: begin
				s_nxt.out = 1'b0;
				s_nxt.oe = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign timer_out = s_r.out;
	assign timer_out_oe = s_r.oe;
	assign awready = s_r.awready;
	assign wready = s_r.wready;
	assign bvalid = s_r.bvalid;
	assign bresp = s_r.bresp;
	assign arready = s_r.arready;
	assign rvalid = s_r.rvalid;
	assign rdata = s_r.rdata;
	assign rresp = s_r.rresp;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence seq_on_count;
		run && !clr;
	endsequence

	AST_COUNT_STEP: assert property (seq_on_count |=>
		s_r.cnt == $past(s_r.cnt) + 16'h0001)
		else $error("counter did not step by one");

	AST_P_CLEARS: assert property (run && mode != CPT_MODE_PWM &&
		!s_r.ctl[`CPT_BIT_SEL] && hit_p |=> s_r.cnt == 16'h0000 && s_r.flag_p)
		else $error("P match did not clear counter and set flag");

	AST_A_CLEARS: assert property (run && mode != CPT_MODE_PWM &&
		s_r.ctl[`CPT_BIT_SEL] && hit_a && s_r.cmpa != 16'h0000
		|=> s_r.cnt == 16'h0000 && s_r.flag_a)
		else $error("A match did not clear counter and set flag");

	AST_NO_P_FLAG: assert property (mode != CPT_MODE_PWM &&
		s_r.ctl[`CPT_BIT_SEL] && !s_r.flag_p |=> !s_r.flag_p)
		else $error("P flag set while A clears the counter");

	AST_WRAP_NO_A: assert property (run && mode != CPT_MODE_PWM &&
		s_r.ctl[`CPT_BIT_SEL] && s_r.cmpa == 16'h0000 && !s_r.flag_a
		|=> !s_r.flag_a &&
		(s_r.cnt != 16'h0000 || $past(s_r.cnt) == 16'hFFFF))
		else $error("A flag set on wrap with zero A value");

	AST_START_PIN: assert property ($rose(s_r.on) |->
		s_r.pin == s_r.ctl[`CPT_BIT_INIT] && s_r.cnt == 16'h0000)
		else $error("pin or counter not restarted by switch-on");

	AST_TC_FREE: assert property (mode == CPT_MODE_TC |=>
		!timer_out_oe)
		else $error("pin driven in timer/counter mode");

	sequence seq_pwm_full;
		mode == CPT_MODE_PWM && act == `CPT_ACT_HIGH &&
		!s_r.ctl[`CPT_BIT_SWAP] && s_r.cmpp != 8'h00 &&
		s_r.cmpa >= {s_r.cmpp, 8'h00};
	endsequence

	AST_PWM_FULL: assert property (seq_pwm_full ##1 seq_pwm_full |->
		timer_out == (s_r.ctl[`CPT_BIT_INIT] ^ s_r.ctl[`CPT_BIT_INV]))
		else $error("full duty not held at active level");

	AST_PWM_FORCE: assert property ((mode == CPT_MODE_PWM &&
		act == `CPT_ACT_LOW)[*2] |-> timer_out ==
		(s_r.ctl[`CPT_BIT_INIT] ^ s_r.ctl[`CPT_BIT_INV]))
		else $error("forced active level not on the pin");

	AST_BVALID_HOLD: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped before bready");
endmodule

// [tb/cpt_load.sv]
// external load on the timer pin: resolves the pin, counts high cycles
// assumes: one aclk domain; the pin has a pull-down when not driven
`timescale 1ns/1ps
module cpt_load (
	// clock
	input  wire logic        aclk,
	// pin as the timer drives it
	input  wire logic        timer_out,
	input  wire logic        timer_out_oe,
	// measuring window control and result
	input  wire logic        clr,
	input  wire logic        win,
	output logic      [15:0] high_cnt
);
	logic pin_lvl;

	// a released pin falls to the pull-down, never keeps the last level
	assign pin_lvl = timer_out_oe ? timer_out : 1'b0;

	// high time inside the window gives the duty of the waveform
	always_ff @(posedge aclk) begin
		if (clr)
			high_cnt <= 16'h0000;
		else if (win && pin_lvl)
			high_cnt <= high_cnt + 16'h0001;
	end
endmodule

// [tb/compact_timer_compare_pwm_tb_top.sv]
// self-checking bench of the compact timer over its AXI4-Lite port
// assumes: design files compiled first; count clock made here at aclk/4
`timescale 1ns/1ps
module compact_timer_compare_pwm_tb_top
	import cpt_pkg::*;
;
	// ********************************************************
	// signals and instances
	// ********************************************************
	logic        aclk, aresetn, count_clk_in, timer_out, timer_out_oe;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, clr, win;
	logic [15:0] high_cnt;
	int          miscompares, comparisons;

	cpt_top i_cpt_top (.aclk(aclk), .aresetn(aresetn),
		.count_clk_in(count_clk_in), .timer_out(timer_out),
		.timer_out_oe(timer_out_oe), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	cpt_load i_cpt_load (.aclk(aclk), .timer_out(timer_out),
		.timer_out_oe(timer_out_oe), .clr(clr), .win(win),
		.high_cnt(high_cnt));

	// ********************************************************
	// bus, stimulus and compare tasks
	// ********************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkb(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// handshakes are judged at the negedge, so the edge never races
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er);
		logic pa, pw, b;
		logic [1:0] r;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw) begin
			@(negedge aclk);
			if (awvalid && awready) pa = 1'b0;
			if (wvalid && wready) pw = 1'b0;
			@(posedge aclk);
			awvalid <= pa;
			wvalid <= pw;
		end
		b = 1'b0;
		while (!b) begin
			@(negedge aclk);
			b = bvalid;
			r = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
		// let an edge pass so the next call never re-drives bready at once
		@(posedge aclk);
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic t;
		logic [31:0] d;
		logic [1:0] r;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		t = 1'b1;
		while (t) begin
			@(negedge aclk);
			t = !arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		while (!t) begin
			@(negedge aclk);
			t = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
		@(posedge aclk);
		chk(d, ed);
		chk({30'h0, r}, {30'h0, er});
	endtask

	// each count clock level lasts two aclk, the fastest legal pace
	task automatic pulses(input int n);
		repeat (n) begin
			count_clk_in <= 1'b1;
			repeat (2) @(posedge aclk);
			count_clk_in <= 1'b0;
			repeat (2) @(posedge aclk);
		end
	endtask

	// timer is stopped before any mode or action change
	task automatic setup(input logic [7:0] ctl, input logic [15:0] a,
		input logic [7:0] p);
		wr(8'h00, 8'h00, 2'h0);
		wr(8'h04, ctl, 2'h0);
		wr(8'h10, a[7:0], 2'h0);
		wr(8'h14, a[15:8], 2'h0);
		wr(8'h18, p, 2'h0);
		wr(8'h1C, 8'h03, 2'h0);
		wr(8'h00, 8'h01, 2'h0);
	endtask

	// ********************************************************
	// scenarios
	// ********************************************************
	task automatic t_regs();
		rchk(8'h08, 32'h0, 2'h0);
		rchk(8'h0C, 32'h0, 2'h0);
		rchk(8'h10, 32'h0, 2'h0);
		rchk(8'h14, 32'h0, 2'h0);
		wr(8'h10, 8'h5A, 2'h0);
		wr(8'h14, 8'hA5, 2'h0);
		// a write with the low strobe off must leave the byte alone
		wstrb <= 4'h0;
		wr(8'h10, 8'hC3, 2'h0);
		wstrb <= 4'hF;
		wr(8'h08, 8'hFF, 2'h0);
		wr(8'h24, 8'h01, 2'h2);
		rchk(8'h10, 32'h5A, 2'h0);
		rchk(8'h14, 32'hA5, 2'h0);
		rchk(8'h08, 32'h0, 2'h0);
		rchk(8'h20, 32'h0, 2'h2);
		$display("test registers done");
	endtask

	task automatic t_cmp();
		setup(8'h30, 16'h0010, 8'h01);
		chkb(timer_out_oe, 1'b1);
		pulses(15);
		chkb(timer_out, 1'b0);
		pulses(1);
		chkb(timer_out, 1'b1);
		rchk(8'h08, 32'h10, 2'h0);
		rchk(8'h1C, 32'h1, 2'h0);
		pulses(239);
		rchk(8'h08, 32'hFF, 2'h0);
		rchk(8'h1C, 32'h1, 2'h0);
		pulses(1);
		chkb(timer_out, 1'b1);
		rchk(8'h0C, 32'h0, 2'h0);
		rchk(8'h1C, 32'h3, 2'h0);
		// action codes none, low and high; low and high each start from the level they change
		for (int m = 0; m < 3; m++) begin
			setup({2'b00, m[1:0], m != 2, 3'b000}, 16'h0001, 8'h01);
			pulses(1);
			chkb(timer_out, m != 1);
		end
		$display("test compare output done");
	endtask

	task automatic t_clra();
		setup(8'h31, 16'h0120, 8'h01);
		chkb(timer_out, 1'b0);
		pulses(287);
		rchk(8'h0C, 32'h01, 2'h0);
		rchk(8'h08, 32'h1F, 2'h0);
		rchk(8'h1C, 32'h0, 2'h0);
		pulses(1);
		rchk(8'h08, 32'h0, 2'h0);
		rchk(8'h1C, 32'h1, 2'h0);
		chkb(timer_out, 1'b1);
		// A at zero: no clear before the wrap, and no P clear or flag
		setup(8'h31, 16'h0000, 8'h01);
		pulses(300);
		rchk(8'h0C, 32'h01, 2'h0);
		rchk(8'h08, 32'h2C, 2'h0);
		rchk(8'h1C, 32'h0, 2'h0);
		chkb(timer_out, 1'b0);
		$display("test clear on compare A done");
	endtask

	task automatic t_tc();
		setup(8'hC0, 16'h0005, 8'h01);
		pulses(5);
		chkb(timer_out_oe, 1'b0);
		rchk(8'h1C, 32'h1, 2'h0);
		rchk(8'h08, 32'h5, 2'h0);
		$display("test timer counter done");
	endtask

	// window of 512 counts holds whole periods; high aclk cycles counted
	task automatic t_pwm();
		logic [7:0]  ctl[6] = '{8'hA9, 8'hA9, 8'h89, 8'h99, 8'hAD, 8'hAB};
		logic [15:0] dut[6] = '{16'h40, 16'h101, 16'h40, 16'h40, 16'h40,
			16'h200};
		logic [15:0] hi[6] = '{16'd512, 16'd2048, 16'd0, 16'd2048,
			16'd1536, 16'd1024};
		logic [31:0] st[6] = '{32'h3, 32'h2, 32'h3, 32'h3, 32'h3, 32'h3};
		for (int i = 0; i < 6; i++) begin
			setup(ctl[i], dut[i], 8'h01);
			pulses(8);
			clr <= 1'b1;
			@(posedge aclk);
			clr <= 1'b0;
			win <= 1'b1;
			pulses(512);
			win <= 1'b0;
			@(posedge aclk);
			chk({16'h0, high_cnt}, {16'h0, hi[i]});
			rchk(8'h1C, st[i], 2'h0);
		end
		$display("test pwm done");
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ********************************************************
	// clock, reset, sequence and watchdog
	// ********************************************************
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	initial begin
		{aresetn, count_clk_in, awvalid, wvalid, bready} = '0;
		{arvalid, rready, clr, win, awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_regs();
		t_cmp();
		t_clra();
		t_tc();
		t_pwm();
		tally_and_finish();
	end

	// the tests need about 16000 cycles; nearly four times that means a hang
	initial begin
		repeat (60000) @(posedge aclk);
		miscompares++;
		tally_and_finish();
	end
endmodule
